// ### core/pbhp_bus_if.sv
// pbhp_bus_if: host bus between the processor end and the device end
// assumes: both ends clocked by the same sys_clk; no pin is two-way
`timescale 1ns/10ps
`default_nettype none
interface pbhp_bus_if;
  logic chip_sel;
  logic port_sel;
  logic wr_stb;
  logic rd_stb;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport device (input chip_sel, input port_sel, input wr_stb, input rd_stb, input wdata, output rdata);
  modport host (output chip_sel, output port_sel, output wr_stb, output rd_stb, output wdata, input rdata);
endinterface : pbhp_bus_if
`default_nettype wire

// ### core/pbhp_device.sv
// pbhp_device: register file, packet memory and buffer logic of the device end
// assumes: host bus, mac side and config levels all on sys_clk, no sync needed
//
// ****************************************
// ****************************************
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module pbhp_device (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // host bus
  pbhp_bus_if.device bus,
  // configuration levels
  input wire logic cs_active_high,
  input wire logic bus16_mode,
  // transmit side
  output logic tx_start,
  output logic [13:0] tx_addr,
  output logic [15:0] tx_len,
  output logic tx_crc_off,
  output logic tx_pad_off,
  input wire logic tx_done,
  input wire logic [7:0] tx_done_status,
  // receive side
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic [7:0] rx_status,
  // interrupt
  output logic irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] index;
    logic [15:0] rdata, dbuf;
    logic [13:0] maddr;
    logic [7:0] tx_ctrl, stat1, stat2;
    logic [15:0] len;
    logic [7:0] int_mask, isr;
    logic irq, tx_start, tx_slot, done_slot;
    logic [1:0] pending;
    logic [13:0] tx_addr;
    logic [15:0] tx_len;
    logic [13:0] rx_start, rx_wp;
    logic [15:0] rx_cnt;
  } pbhp_dev_state_t;

  localparam pbhp_dev_state_t DEV_RESET = '{
    tx_addr: pbhp_pkg::TX_SLOT1_BASE,
    rx_start: pbhp_pkg::RX_BASE,
    rx_wp: pbhp_pkg::RX_FIRST_WP,
    default: '0
  };

  pbhp_dev_state_t s_reg, s_next;
  logic [7:0] mem [0:pbhp_pkg::MEM_BYTES-1];

  logic sel, wr_d, rd_d, host_we, hdr_we;
  logic [13:0] step, pre_addr, pre_addr1, host_wa1, hdr_a1, hdr_a2, hdr_a3, nstart;
  logic [15:0] hdr_len;
  logic [7:0] rdval, set_vec, clr_vec;

  // ****************************************
  // address arithmetic
  // ****************************************
  function automatic logic [13:0] next_addr(input logic [13:0] a, input logic [13:0] st, input logic wrap,
                                            input logic is_wr);
    logic [14:0] s;
    s = {1'b0, a} + {1'b0, st};
    if (wrap && is_wr && s >= {1'b0, pbhp_pkg::TX_END}) begin
      s = s - {1'b0, pbhp_pkg::TX_END};
    end else if (wrap && !is_wr && s[14]) begin
      s = {1'b0, pbhp_pkg::RX_BASE} + {1'b0, s[13:0]};
    end
    return s[13:0];
  endfunction : next_addr

  // receive ring never leaves the receive area
  function automatic logic [13:0] ring_add(input logic [13:0] a, input logic [13:0] n);
    logic [14:0] s;
    s = {1'b0, a} + {1'b0, n};
    if (s[14]) begin
      s = {1'b0, pbhp_pkg::RX_BASE} + {1'b0, s[13:0]};
    end
    return s[13:0];
  endfunction : ring_add

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.tx_start = 1'b0;
    sel = cs_active_high ? bus.chip_sel : ~bus.chip_sel;
    wr_d = sel && bus.wr_stb && (bus.port_sel == pbhp_pkg::PORT_DATA);
    rd_d = sel && bus.rd_stb && (bus.port_sel == pbhp_pkg::PORT_DATA);
    step = bus16_mode ? 14'h0002 : 14'h0001;
    pre_addr = s_reg.maddr;
    host_we = 1'b0;
    hdr_we = 1'b0;
    set_vec = 8'h00;
    clr_vec = 8'h00;
    nstart = s_reg.rx_start;
    hdr_len = s_reg.rx_cnt + 16'h0001;
    // pointer only changes on a pointer port write
    if (sel && bus.wr_stb && (bus.port_sel == pbhp_pkg::PORT_INDEX)) begin
      s_next.index = bus.wdata[7:0];
    end
    // register read mux
    unique case (s_reg.index)
      pbhp_pkg::IDX_TX_CTRL: begin
        rdval = s_reg.tx_ctrl;
        rdval[pbhp_pkg::CTRL_START_BIT] = (s_reg.pending != 2'h0);
      end
      pbhp_pkg::IDX_TX_STAT1: rdval = s_reg.stat1;
      pbhp_pkg::IDX_TX_STAT2: rdval = s_reg.stat2;
      pbhp_pkg::IDX_MEM_ADDR_L: rdval = s_reg.maddr[7:0];
      pbhp_pkg::IDX_MEM_ADDR_H: rdval = {2'h0, s_reg.maddr[13:8]};
      pbhp_pkg::IDX_RX_START_L: rdval = s_reg.rx_start[7:0];
      pbhp_pkg::IDX_RX_START_H: rdval = {2'h0, s_reg.rx_start[13:8]};
      pbhp_pkg::IDX_LEN_L: rdval = s_reg.len[7:0];
      pbhp_pkg::IDX_LEN_H: rdval = s_reg.len[15:8];
      pbhp_pkg::IDX_INT_STATUS: rdval = s_reg.isr;
      pbhp_pkg::IDX_INT_MASK: rdval = s_reg.int_mask;
      default: rdval = 8'h00;
    endcase
    if (rd_d) begin
      if (s_reg.index == pbhp_pkg::IDX_MEM_RD || s_reg.index == pbhp_pkg::IDX_MEM_RD_DUMMY) begin
        // dummy read returns whatever the buffer held before
        s_next.rdata = bus16_mode ? s_reg.dbuf : {8'h00, s_reg.dbuf[7:0]};
      end else begin
        s_next.rdata = {8'h00, rdval};
      end
      if (s_reg.index == pbhp_pkg::IDX_MEM_RD) begin
        pre_addr = next_addr(s_reg.maddr, step, s_reg.int_mask[pbhp_pkg::INT_MASK_WRAP_BIT], 1'b0);
        s_next.maddr = pre_addr;
      end
      if (s_reg.index == pbhp_pkg::IDX_INT_STATUS) begin
        clr_vec = s_reg.isr;
      end
    end
    if (wr_d) begin
      unique case (s_reg.index)
        pbhp_pkg::IDX_MEM_ADDR_L: s_next.maddr[7:0] = bus.wdata[7:0];
        pbhp_pkg::IDX_MEM_ADDR_H: s_next.maddr[13:8] = bus.wdata[5:0];
        pbhp_pkg::IDX_LEN_L: s_next.len[7:0] = bus.wdata[7:0];
        pbhp_pkg::IDX_LEN_H: s_next.len[15:8] = bus.wdata[7:0];
        pbhp_pkg::IDX_INT_MASK: s_next.int_mask = bus.wdata[7:0];
        pbhp_pkg::IDX_MEM_WR: begin
          host_we = 1'b1;
          pre_addr = next_addr(s_reg.maddr, step, s_reg.int_mask[pbhp_pkg::INT_MASK_WRAP_BIT], 1'b1);
          s_next.maddr = pre_addr;
        end
        pbhp_pkg::IDX_TX_CTRL: begin
          s_next.tx_ctrl = bus.wdata[7:0];
          s_next.tx_ctrl[pbhp_pkg::CTRL_START_BIT] = 1'b0;
          // a third start while both slots are busy is dropped
          if (bus.wdata[pbhp_pkg::CTRL_START_BIT] && s_reg.pending != 2'h2) begin
            s_next.tx_start = 1'b1;
            s_next.tx_addr = s_reg.tx_slot ? pbhp_pkg::TX_SLOT2_BASE : pbhp_pkg::TX_SLOT1_BASE;
            s_next.tx_len = s_reg.len;
            s_next.tx_slot = ~s_reg.tx_slot;
          end
        end
        default: begin
        end
      endcase
    end
    // preload after any buffer command, dummy write included
    pre_addr1 = pre_addr + 14'h0001;
    if ((rd_d || wr_d) && (s_reg.index == pbhp_pkg::IDX_MEM_RD || s_reg.index == pbhp_pkg::IDX_MEM_RD_DUMMY
                           || s_reg.index == pbhp_pkg::IDX_MEM_WR)) begin
      s_next.dbuf = {mem[pre_addr1], mem[pre_addr]};
    end
    // transmit completion, slots finish in start order
    if (tx_done) begin
      if (s_reg.done_slot) begin
        s_next.stat2 = tx_done_status;
      end else begin
        s_next.stat1 = tx_done_status;
      end
      s_next.done_slot = ~s_reg.done_slot;
      set_vec[pbhp_pkg::INT_TX_BIT] = 1'b1;
    end
    s_next.pending = s_reg.pending + {1'b0, s_next.tx_start} - {1'b0, tx_done};
    // receive ring writer
    if (rx_valid) begin
      s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
      s_next.rx_wp = ring_add(s_reg.rx_wp, 14'h0001);
      if (rx_last) begin
        hdr_we = 1'b1;
        nstart = ring_add(s_reg.rx_wp, 14'h0001);
        if (bus16_mode && nstart[0]) begin
          nstart = ring_add(nstart, 14'h0001);
        end
        s_next.rx_start = nstart;
        s_next.rx_wp = ring_add(nstart, pbhp_pkg::RX_HDR_BYTES);
        s_next.rx_cnt = 16'h0000;
        set_vec[pbhp_pkg::INT_RX_BIT] = 1'b1;
      end
    end
    // new events win over a read clear
    s_next.isr = ((s_reg.isr & ~clr_vec) | set_vec) & pbhp_pkg::INT_EVENTS;
    s_next.irq = |(s_next.isr & s_next.int_mask & pbhp_pkg::INT_EVENTS);
  end

  assign host_wa1 = s_reg.maddr + 14'h0001;
  assign hdr_a1 = ring_add(s_reg.rx_start, 14'h0001);
  assign hdr_a2 = ring_add(s_reg.rx_start, 14'h0002);
  assign hdr_a3 = ring_add(s_reg.rx_start, 14'h0003);

  // ****************************************
  // registers and memory
  // ****************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= DEV_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // no reset on the array; contents are undefined until written
  always_ff @(posedge sys_clk) begin
    if (host_we) begin
      mem[s_reg.maddr] <= bus.wdata[7:0];
      if (bus16_mode) begin
        mem[host_wa1] <= bus.wdata[15:8];
      end
    end
    if (rx_valid) begin
      mem[s_reg.rx_wp] <= rx_data;
    end
    if (hdr_we) begin
      mem[s_reg.rx_start] <= pbhp_pkg::RX_HDR_MARK;
      mem[hdr_a1] <= rx_status;
      mem[hdr_a2] <= hdr_len[7:0];
      mem[hdr_a3] <= hdr_len[15:8];
    end
  end

  assign bus.rdata = s_reg.rdata;
  assign tx_start = s_reg.tx_start;
  assign tx_addr = s_reg.tx_addr;
  assign tx_len = s_reg.tx_len;
  assign tx_crc_off = s_reg.tx_ctrl[pbhp_pkg::CTRL_CRC_OFF_BIT];
  assign tx_pad_off = s_reg.tx_ctrl[pbhp_pkg::CTRL_PAD_OFF_BIT];
  assign irq = s_reg.irq;
endmodule : pbhp_device
`default_nettype wire

// ### core/pbhp_host.sv
// pbhp_host: processor end, turns single requests into pointer and data accesses
// assumes: device end on the same sys_clk; read data stands one cycle after rd_stb
`timescale 1ns/10ps
`default_nettype none
module pbhp_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // host bus
  pbhp_bus_if.host bus,
  // configuration
  input wire logic cs_active_high,
  // request port
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic [7:0] req_index,
  input wire logic [15:0] req_data,
  output logic req_ready,
  // answer port
  output logic resp_valid,
  output logic [15:0] resp_data
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pbhp_pkg::pbhp_host_state_t st;
    logic [1:0] op;
    logic [7:0] index;
    logic [15:0] data;
    logic idx_valid;
    logic chip_sel;
    logic port_sel;
    logic wr_stb;
    logic rd_stb;
    logic [15:0] wdata;
    logic req_ready;
    logic resp_valid;
    logic [15:0] resp_data;
  } pbhp_host_reg_t;

  localparam pbhp_host_reg_t HOST_RESET = '{st: pbhp_pkg::PBHP_ST_IDLE, default: '0};

  pbhp_host_reg_t h_reg;
  pbhp_host_reg_t h_next;

  always_comb begin
    h_next = h_reg;
    h_next.wr_stb = 1'b0;
    h_next.rd_stb = 1'b0;
    h_next.resp_valid = 1'b0;
    h_next.chip_sel = ~cs_active_high;
    unique case (h_reg.st)
      pbhp_pkg::PBHP_ST_IDLE: begin
        h_next.req_ready = 1'b1;
        if (req_valid && h_reg.req_ready) begin
          h_next.req_ready = 1'b0;
          h_next.op = req_op;
          h_next.index = req_index;
          h_next.data = req_data;
          h_next.chip_sel = cs_active_high;
          // the device keeps its pointer, so a repeat index skips the pointer write
          if (h_reg.idx_valid && h_reg.index == req_index) begin
            h_next.port_sel = pbhp_pkg::PORT_DATA;
            h_next.wr_stb = (req_op == pbhp_pkg::OP_WR);
            h_next.rd_stb = (req_op != pbhp_pkg::OP_WR);
            h_next.wdata = req_data;
            h_next.st = pbhp_pkg::PBHP_ST_DATA;
          end else begin
            h_next.port_sel = pbhp_pkg::PORT_INDEX;
            h_next.wr_stb = 1'b1;
            h_next.wdata = {8'h00, req_index};
            h_next.idx_valid = 1'b1;
            h_next.st = pbhp_pkg::PBHP_ST_PTR;
          end
        end
      end
      pbhp_pkg::PBHP_ST_PTR: begin
        // length, start and buffer writes pass through here in order, except a repeat index, which goes straight to the data state
        h_next.chip_sel = cs_active_high;
        h_next.port_sel = pbhp_pkg::PORT_DATA;
        h_next.wr_stb = (h_reg.op == pbhp_pkg::OP_WR);
        h_next.rd_stb = (h_reg.op != pbhp_pkg::OP_WR);
        h_next.wdata = h_reg.data;
        h_next.st = pbhp_pkg::PBHP_ST_DATA;
      end
      pbhp_pkg::PBHP_ST_DATA: begin
        if (h_reg.op == pbhp_pkg::OP_WR) begin
          h_next.resp_valid = 1'b1;
          h_next.resp_data = 16'h0000;
          h_next.req_ready = 1'b1;
          h_next.st = pbhp_pkg::PBHP_ST_IDLE;
        end else begin
          h_next.st = pbhp_pkg::PBHP_ST_CAPT;
        end
      end
      pbhp_pkg::PBHP_ST_CAPT: begin
        h_next.resp_valid = 1'b1;
        // stale buffer contents from the dummy read are thrown away
        h_next.resp_data = (h_reg.op == pbhp_pkg::OP_DUMMY) ? 16'h0000 : bus.rdata;
        h_next.req_ready = 1'b1;
        h_next.st = pbhp_pkg::PBHP_ST_IDLE;
      end
      default: begin
        h_next = HOST_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      h_reg <= HOST_RESET;
    end else begin
      h_reg <= h_next;
    end
  end

  assign bus.chip_sel = h_reg.chip_sel;
  assign bus.port_sel = h_reg.port_sel;
  assign bus.wr_stb = h_reg.wr_stb;
  assign bus.rd_stb = h_reg.rd_stb;
  assign bus.wdata = h_reg.wdata;
  assign req_ready = h_reg.req_ready;
  assign resp_valid = h_reg.resp_valid;
  assign resp_data = h_reg.resp_data;
endmodule : pbhp_host
`default_nettype wire

// ### core/pbhp_pkg.sv
// pbhp_pkg: shared constants and types of the packet buffer host port
// assumes: both ends run on the same sys_clk and import nothing
package pbhp_pkg;
  // ****************************************
  // memory layout
  // ****************************************
  localparam int MEM_BYTES = 16384;
  localparam logic [13:0] TX_END = 14'h0c00;
  localparam logic [13:0] RX_BASE = 14'h0c00;
  localparam logic [13:0] TX_SLOT1_BASE = 14'h0000;
  localparam logic [13:0] TX_SLOT2_BASE = 14'h0600;
  localparam logic [13:0] RX_HDR_BYTES = 14'h0004;
  localparam logic [13:0] RX_FIRST_WP = RX_BASE + RX_HDR_BYTES;
  localparam logic [7:0] RX_HDR_MARK = 8'h01;
  // ****************************************
  // port select and register indexes
  // ****************************************
  localparam logic PORT_INDEX = 1'b0;
  localparam logic PORT_DATA = 1'b1;
  localparam logic [7:0] IDX_TX_CTRL = 8'h02;
  localparam logic [7:0] IDX_TX_STAT1 = 8'h03;
  localparam logic [7:0] IDX_TX_STAT2 = 8'h04;
  localparam logic [7:0] IDX_MEM_RD_DUMMY = 8'hf0;
  localparam logic [7:0] IDX_MEM_RD = 8'hf2;
  localparam logic [7:0] IDX_MEM_ADDR_L = 8'hf4;
  localparam logic [7:0] IDX_MEM_ADDR_H = 8'hf5;
  localparam logic [7:0] IDX_RX_START_L = 8'hf6;
  localparam logic [7:0] IDX_RX_START_H = 8'hf7;
  localparam logic [7:0] IDX_MEM_WR = 8'hf8;
  localparam logic [7:0] IDX_LEN_L = 8'hfc;
  localparam logic [7:0] IDX_LEN_H = 8'hfd;
  localparam logic [7:0] IDX_INT_STATUS = 8'hfe;
  localparam logic [7:0] IDX_INT_MASK = 8'hff;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_CRC_OFF_BIT = 2;
  localparam int CTRL_PAD_OFF_BIT = 3;
  localparam int INT_MASK_WRAP_BIT = 7;
  localparam int INT_RX_BIT = 0;
  localparam int INT_TX_BIT = 1;
  localparam logic [7:0] INT_EVENTS = 8'h03;
  // ****************************************
  // host commands and states
  // ****************************************
  localparam logic [1:0] OP_WR = 2'h0;
  localparam logic [1:0] OP_RD = 2'h1;
  localparam logic [1:0] OP_DUMMY = 2'h2;
  typedef enum logic [3:0] {
    PBHP_ST_IDLE = 4'h1,
    PBHP_ST_PTR = 4'h2,
    PBHP_ST_DATA = 4'h4,
    PBHP_ST_CAPT = 4'h8
  } pbhp_host_state_t;
endpackage : pbhp_pkg

// ### sim/packet_buffer_host_port_tb.sv
// packet_buffer_host_port_tb: host end and device end joined, one task per scenario
// assumes: one sys_clk at 100 MHz, outputs of both ends registered
`timescale 1ns/10ps
`default_nettype none
module packet_buffer_host_port_tb;
  logic sys_clk, nrst, cs_active_high, bus16_mode, tx_done, rx_valid, rx_last;
  logic req_valid, req_ready, resp_valid, tx_start, tx_crc_off, tx_pad_off, irq;
  logic [7:0] tx_done_status, rx_data, rx_status, req_index;
  logic [1:0] req_op;
  logic [13:0] tx_addr;
  logic [15:0] tx_len, req_data, resp_data, r, v;
  int mismatches, samples_checked, starts;
  pbhp_bus_if pbhp_bus_if_inst ();
  pbhp_device pbhp_device_inst (.sys_clk(sys_clk), .nrst(nrst), .bus(pbhp_bus_if_inst),
    .cs_active_high(cs_active_high), .bus16_mode(bus16_mode), .tx_start(tx_start), .tx_addr(tx_addr),
    .tx_len(tx_len), .tx_crc_off(tx_crc_off), .tx_pad_off(tx_pad_off), .tx_done(tx_done),
    .tx_done_status(tx_done_status), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_status(rx_status), .irq(irq));
  pbhp_host pbhp_host_inst (.sys_clk(sys_clk), .nrst(nrst), .bus(pbhp_bus_if_inst),
    .cs_active_high(cs_active_high), .req_valid(req_valid), .req_op(req_op), .req_index(req_index),
    .req_data(req_data), .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data));
  pbhp_checker pbhp_checker_inst (.sys_clk(sys_clk), .nrst(nrst), .cs_active_high(cs_active_high),
    .chip_sel(pbhp_bus_if_inst.chip_sel), .port_sel(pbhp_bus_if_inst.port_sel),
    .wr_stb(pbhp_bus_if_inst.wr_stb), .rd_stb(pbhp_bus_if_inst.rd_stb), .rdata(pbhp_bus_if_inst.rdata));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // counted mid-cycle so a task returning on the next edge already sees it
  always @(negedge sys_clk) begin
    if (tx_start === 1'b1) begin
      starts++;
    end
  end
  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one request through the host end, bounded waits on ready and answer
  task automatic op(input logic [1:0] o, input logic [7:0] i, input logic [15:0] d);
    int n;
    n = 0;
    req_op <= o;
    req_index <= i;
    req_data <= d;
    req_valid <= 1'b1;
    @(posedge sys_clk);
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    req_valid <= 1'b0;
    @(posedge sys_clk);
    while (resp_valid !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    r = resp_data;
    if (resp_valid !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no answer from host end", $time);
      finish_test();
    end
  endtask : op
  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    op(pbhp_pkg::OP_WR, i, d);
  endtask : wr
  task automatic rd(input logic [7:0] i);
    op(pbhp_pkg::OP_RD, i, 16'h0000);
  endtask : rd
  task automatic rd2(input logic [7:0] i);
    rd(i);
    v[7:0] = r[7:0];
    rd(i + 8'h01);
    v[15:8] = r[7:0];
  endtask : rd2
  task automatic seek(input logic [15:0] a);
    wr(8'hf4, {8'h00, a[7:0]});
    wr(8'hf5, {8'h00, a[15:8]});
  endtask : seek
  task automatic preload(input logic [15:0] a);
    seek(a);
    op(pbhp_pkg::OP_DUMMY, 8'hf0, 16'h0000);
    chk(r, 16'h0000);
  endtask : preload
  task automatic done(input logic [7:0] st);
    tx_done <= 1'b1;
    tx_done_status <= st;
    @(posedge sys_clk);
    tx_done <= 1'b0;
    @(posedge sys_clk);
  endtask : done
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask : do_reset
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk({2'b00, tx_addr}, 16'h0000);
    rd2(8'hf6);
    chk(v, 16'h0c00);
    rd(8'h02);
    chk(r & 16'h00ff, 16'h0000);
    wr(8'h40, 16'h00a5);
    rd(8'h40);
    chk(r, 16'h0000);
  endtask : t_reset
  task automatic t_mem;
    seek(16'h0010);
    for (int i = 1; i < 4; i++) begin
      wr(8'hf8, 16'h1111 * 16'(i));
    end
    rd2(8'hf4);
    chk(v, 16'h0016);
    preload(16'h0010);
    for (int i = 1; i < 4; i++) begin
      rd(8'hf2);
      chk(r, 16'h1111 * 16'(i));
    end
  endtask : t_mem
  task automatic t_wrap;
    wr(8'hff, 16'h0080);
    seek(16'h0bfe);
    wr(8'hf8, 16'haaaa);
    wr(8'hf8, 16'hbbbb);
    rd2(8'hf4);
    chk(v, 16'h0002);
    wr(8'hff, 16'h0000);
    seek(16'h3ffe);
    wr(8'hf8, 16'hcccc);
    rd2(8'hf4);
    chk(v, 16'h0000);
    seek(16'h0c00);
    wr(8'hf8, 16'hdddd);
    wr(8'hff, 16'h0080);
    preload(16'h3ffe);
    rd(8'hf2);
    chk(r, 16'hcccc);
    rd(8'hf2);
    chk(r, 16'hdddd);
    preload(16'h0000);
    rd(8'hf2);
    chk(r, 16'hbbbb);
  endtask : t_wrap
  task automatic t_tx;
    int s;
    s = starts;
    wr(8'hff, 16'h0002);
    wr(8'hfc, 16'h0040);
    wr(8'hfd, 16'h0000);
    wr(8'h02, 16'h000e);
    chk(16'(starts - s), 16'h0001);
    chk({2'b00, tx_addr}, 16'h0000);
    chk(tx_len, 16'h0040);
    chk({14'h0000, tx_crc_off, tx_pad_off}, 16'h0003);
    rd(8'h02);
    chk(r & 16'h0002, 16'h0002);
    // slot two count and start wait until slot one has finished
    done(8'h11);
    chk({15'h0000, irq}, 16'h0001);
    wr(8'h03, 16'h00ff);
    rd(8'h03);
    chk(r & 16'h00ff, 16'h0011);
    rd(8'hfe);
    chk(r & 16'h00ff, 16'h0002);
    chk({15'h0000, irq}, 16'h0000);
    wr(8'hfc, 16'h0041);
    wr(8'h02, 16'h0002);
    chk({2'b00, tx_addr}, 16'h0600);
    chk(tx_len, 16'h0041);
    chk(16'(starts - s), 16'h0002);
    wr(8'hff, 16'h0000);
    done(8'h22);
    chk({15'h0000, irq}, 16'h0000);
    rd(8'h04);
    chk(r & 16'h00ff, 16'h0022);
    wr(8'h02, 16'h0002);
    chk({2'b00, tx_addr}, 16'h0000);
    chk(16'(starts - s), 16'h0003);
  endtask : t_tx
  task automatic t_rx;
    wr(8'hff, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      rx_valid <= 1'b1;
      rx_data <= 8'h30 + 8'(i);
      rx_last <= (i == 4);
      rx_status <= 8'h5a;
      @(posedge sys_clk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({15'h0000, irq}, 16'h0001);
    rd2(8'hf6);
    chk(v, 16'h0c0a);
    preload(16'h0c00);
    rd(8'hf2);
    chk(r, 16'h5a01);
    rd(8'hf2);
    chk(r, 16'h0005);
    rd(8'hf2);
    chk(r, 16'h3130);
  endtask : t_rx
  // polarity and width are straps, so they change only across a reset
  task automatic t_polar;
    cs_active_high <= 1'b1;
    bus16_mode <= 1'b0;
    do_reset();
    wr(8'hff, 16'h0083);
    rd(8'hff);
    chk(r & 16'h00ff, 16'h0083);
    seek(16'h0020);
    wr(8'hf8, 16'h12ab);
    wr(8'hf8, 16'h34cd);
    rd2(8'hf4);
    chk(v, 16'h0022);
    preload(16'h0020);
    rd(8'hf2);
    chk(r, 16'h00ab);
    rd(8'hf2);
    chk(r, 16'h00cd);
    // dummy write form of the preload, address must not move
    seek(16'h0020);
    wr(8'hf0, 16'h0000);
    rd(8'hf2);
    chk(r, 16'h00ab);
  endtask : t_polar
  initial begin
    {cs_active_high, tx_done, rx_valid, rx_last, req_valid} = 5'h00;
    {tx_done_status, rx_data, rx_status, req_index} = 32'h0000_0000;
    {req_op, req_data} = 18'h00000;
    bus16_mode = 1'b1;
    do_reset();
    t_reset();
    t_mem();
    t_wrap();
    t_tx();
    t_rx();
    t_polar();
    finish_test();
  end
endmodule : packet_buffer_host_port_tb
`default_nettype wire

// ### sim/pbhp_checker.sv
// pbhp_checker: timing relations on the bus between host end and device end
// assumes: instantiated beside the bus interface, one clock, async low reset
`timescale 1ns/10ps
`default_nettype none
module pbhp_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // bus and select polarity
  input wire logic cs_active_high,
  input wire logic chip_sel,
  input wire logic port_sel,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata
);
  logic sel_on;
  logic ptr_seen_reg;
  assign sel_on = (chip_sel == cs_active_high);
  // data accesses are only legal once a pointer exists
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_seen_reg <= 1'b0;
    end else if (wr_stb && !port_sel && sel_on) begin
      ptr_seen_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // ****************************************
  // assertions
  // ****************************************
  chk_strobe_excl: assert property (!(wr_stb && rd_stb))
    else $error("write and read strobe together");
  chk_read_data_port: assert property (rd_stb |-> port_sel)
    else $error("read of pointer port");
  chk_strobe_selected: assert property ((wr_stb || rd_stb) |-> sel_on)
    else $error("strobe without active select");
  chk_ptr_before_data: assert property ((wr_stb || rd_stb) && port_sel |-> ptr_seen_reg)
    else $error("data access before any pointer write");
  chk_ptr_then_data: assert property (wr_stb && !port_sel |=> (wr_stb || rd_stb) && port_sel)
    else $error("pointer write not followed by data access");
  chk_read_spacing: assert property (rd_stb |=> (!wr_stb && !rd_stb) [*2])
    else $error("bus busy right after a read");
  chk_rdata_hold: assert property ($changed(rdata) |-> $past(rd_stb && port_sel && sel_on))
    else $error("read data moved without a data read");
  chk_idle_deselect: assert property ($past(rd_stb) && !wr_stb && !rd_stb |-> !sel_on)
    else $error("select still active after read");
endmodule : pbhp_checker
`default_nettype wire
